// *** ddrphy_pkg.sv ***
package ddrphy_pkg;

  // Register byte offsets on the APB word bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MARGIN = 8'h04;
  localparam logic [7:0] OFF_TXWORD = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_DELAY = 8'h10;
  localparam logic [7:0] OFF_RXWORD = 8'h14;

  // Control register fields; update_n resets high so the code holds.
  localparam int C_LOAD = 0;
  localparam int C_PAUSE = 1;
  localparam int C_RSEL = 2;
  localparam int C_WLD = 5;
  localparam int C_UPDN = 13;
  localparam int C_GEAR4 = 14;
  localparam int C_SRST = 15;
  localparam int C_RDGO = 16;
  localparam int C_TXGO = 17;
  localparam logic [15:0] CTRL_RST = 16'h2000;

  // Margin register fields.
  localparam int M_STEP = 0;
  localparam int M_DIR = 1;

  // Transmit word fields.
  localparam int T_DQ = 0;
  localparam int T_DQS = 8;
  localparam int T_DQEN = 16;
  localparam int T_DQSEN = 20;
  localparam int T_AC = 24;

  // One serial bit lasts BIT_NS, rounded up to whole system clock cycles.
  localparam int CLK_NS = 8;
  localparam int BIT_NS = 32;
  localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int QTR_CYC = (BIT_CYC / 4 > 0) ? BIT_CYC / 4 : 1;
  localparam logic [2:0] PH_LAST = 3'(BIT_CYC - 1);
  localparam logic [2:0] PH_QTR = 3'(QTR_CYC);

  // Word sizes, as last bit index, for the two gear ratios.
  localparam logic [2:0] LAST_G2 = 3'h3;
  localparam logic [2:0] LAST_G4 = 3'h7;

  // Strobe delay line.
  localparam int DLY_DEPTH = 64;
  localparam logic [5:0] DLY_MAX = 6'h3F;
  localparam logic [7:0] PER_MAX = 8'hFF;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_LEVEL = 3'b010,
    TX_SEND = 3'b100
  } ddrphy_tx_e;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_PRE = 3'b010,
    RD_CAP = 3'b100
  } ddrphy_rd_e;

  typedef struct packed {
    logic dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
    logic addr_cmd;
  } ddrphy_pins_s;

endpackage

// *** ddrphy_dly_line.sv ***
module ddrphy_dly_line
  import ddrphy_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Strobe in, tap select, delayed strobe out
  input wire logic din,
  input wire logic [5:0] sel,
  output logic dout
);

  typedef struct packed {
    logic [DLY_DEPTH-1:0] taps;
    logic dout;
  } ddrphy_dly_s;

  ddrphy_dly_s q;
  ddrphy_dly_s d;

  // The tap is picked from registers, so dout lags din by sel plus two.
  always_comb
  begin
    d = q;
    d.taps = {q.taps[DLY_DEPTH-2:0], din};
    d.dout = q.taps[sel];
  end

  // The line starts empty, which reads as a low strobe.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.dout;

endmodule // ddrphy_dly_line

// *** ddrphy_top.sv ***
// Contract
// [R1] Strobe is delayed a quarter period by the loop code for capture.
// [R2] One strobe buffer serves a group of sixteen data pins.
// [R3] Load, step and direction raise or lower the applied strobe delay.
// [R4] With load high, loop code changes are ignored; steps must track.
// [R5] Without margin control, load stays low and delay follows the code.
// [R6] Pause is raised before select, leveling or code changes.
// [R7] Read select places the read window after the strobe preamble.
// [R8] A burst detect flag confirms the read window placement.
// [R9] Three-bit read and write pointers move captured bits into words.
// [R10] Write clocks for data and strobe include the leveling delay.
// [R11] Gear two capture gives four bits; even bits on rising edges.
// [R12] Gear four capture gives eight bits; even bits on rising edges.
// [R13] Gear two data output sends four bits, first bit first, early.
// [R14] Gear four data output sends eight bits on the early clock.
// [R15] Gear two strobe output sends four bits in order.
// [R16] Gear four strobe output sends eight bits in order.
// [R17] Gear two data enables send two bits, first then second.
// [R18] Gear four data enables send four bits in order.
// [R19] Gear two strobe enables send two bits on the strobe clock.
// [R20] Gear four strobe enables send four bits in order.
// [R21] Gear two address and command sends two bits per word.
// [R22] Gear four address and command sends four bits per word.
// [R23] Loop code updates only while update_n is low; lock marks valid.
// [R24] Serializer reset clears gearing registers and pointers to idle.
//
// Implementation choices: register access over APB and the placing of the registers.
module ddrphy_top
  import ddrphy_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory pins of one sixteen-bit strobe group, bit lane zero
  input wire logic dq_in,
  input wire logic dqs_in,
  output ddrphy_pkg::ddrphy_pins_s dram_pins
);

  typedef struct packed {
    logic [1:0] dqs_sync;
    logic [1:0] dq_sync;
    logic dqs_prev;
    logic srd_prev;
    logic seen;
    logic [7:0] per_cnt;
    logic [5:0] dll_code;
    logic lock;
    logic [5:0] delay;
    logic [15:0] ctrl;
    logic [27:0] txw;
    ddrphy_rd_e rd_state;
    logic [2:0] skip;
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [7:0] cap;
    logic [7:0] rx_word;
    logic burst_det;
    ddrphy_tx_e tx_state;
    logic [7:0] tx_cnt;
    logic [2:0] ph;
    logic [2:0] bit_idx;
    logic [7:0] sh_dq;
    logic [7:0] sh_dqs;
    logic [3:0] sh_en;
    logic [3:0] sh_sen;
    logic [3:0] sh_ac;
    ddrphy_pins_s pins;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ddrphy_st_s;

  ddrphy_st_s q;
  ddrphy_st_s d;

  logic srd;
  logic setup;
  logic wr_acc;
  logic step;
  logic rd_go;
  logic tx_go;
  logic dqs_rise;
  logic srd_rise;
  logic srd_edge;
  logic [2:0] offset;
  logic [2:0] last;
  logic [5:0] tap;

  // The delay line turns the tap count into the shifted read strobe.
  assign tap = q.delay;
  ddrphy_dly_line u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .din(q.dqs_sync[1]),
    .sel(tap),
    .dout(srd)
  ); // [R1] [R2]

  // Bus decode; a write counts only at the edge where pready is seen high.
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && q.pready && pwrite;
  assign step = wr_acc && (paddr == OFF_MARGIN) && pwdata[M_STEP];
  assign rd_go = wr_acc && (paddr == OFF_CTRL) && pwdata[C_RDGO];
  assign tx_go = wr_acc && (paddr == OFF_CTRL) && pwdata[C_TXGO];
  assign dqs_rise = q.dqs_sync[1] && !q.dqs_prev;
  assign srd_rise = srd && !q.srd_prev;
  assign srd_edge = srd ^ q.srd_prev;
  assign offset = q.wr_ptr - q.rd_ptr;
  assign last = q.ctrl[C_GEAR4] ? LAST_G4 : LAST_G2;

  // All next-state logic of the block in one place.
  always_comb
  begin
    d = q;
    d.dqs_sync = {q.dqs_sync[0], dqs_in};
    d.dq_sync = {q.dq_sync[0], dq_in};
    d.dqs_prev = q.dqs_sync[1];
    d.srd_prev = srd;
    d.pready = 1'b0;
    d.pslverr = 1'b0;

    // Answer is registered, so every access phase lasts one cycle.
    if (setup)
    begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      case (paddr)
        OFF_CTRL: d.prdata = {16'h0000, q.ctrl};
        OFF_MARGIN: d.prdata = 32'h0000_0000;
        OFF_TXWORD: d.prdata = {4'h0, q.txw};
        OFF_STATUS: d.prdata = {23'h000000, q.tx_state != TX_IDLE,
                                q.wr_ptr, q.rd_ptr, q.burst_det, q.lock};
        OFF_DELAY: d.prdata = {20'h00000, q.delay, q.dll_code};
        OFF_RXWORD: d.prdata = {24'h000000, q.rx_word};
        default: d.pslverr = 1'b1;
      endcase
    end
    if (wr_acc && (paddr == OFF_CTRL))
      d.ctrl = pwdata[15:0];
    if (wr_acc && (paddr == OFF_TXWORD))
      d.txw = pwdata[27:0];

    // Period is measured between rising strobe edges; a quarter is the code.
    if (dqs_rise)
    begin
      d.per_cnt = 8'h01;
      d.seen = 1'b1;
      if (!q.ctrl[C_UPDN] && q.seen)
      begin
        d.dll_code = q.per_cnt[7:2]; // [R23]
        d.lock = 1'b1; // [R23]
      end
    end
    else if (q.per_cnt != PER_MAX)
      d.per_cnt = q.per_cnt + 8'h01;

    // Applied delay holds while paused, as the controller relies on.
    if (!q.ctrl[C_PAUSE]) // [R6]
    begin
      if (!q.ctrl[C_LOAD])
        d.delay = q.dll_code; // [R5] [R1]
      else if (step) // [R4]
      begin
        if (pwdata[M_DIR] && (q.delay != 6'h00))
          d.delay = q.delay - 6'h01; // [R3]
        else if (!pwdata[M_DIR] && (q.delay != DLY_MAX))
          d.delay = q.delay + 6'h01; // [R3]
      end
    end

    // Read window: skip preamble edges, then fill one word by pointers.
    if (rd_go)
    begin
      d.rd_state = RD_PRE;
      d.skip = q.ctrl[C_RSEL +: 3]; // [R7]
      d.rd_ptr = q.wr_ptr;
      d.cap = 8'h00;
      d.burst_det = 1'b0;
    end
    else if (!q.ctrl[C_PAUSE])
    begin
      case (q.rd_state)
        RD_IDLE: d.rd_state = RD_IDLE;
        RD_PRE:
          if (srd_rise)
          begin
            if (q.skip == 3'h0)
            begin
              d.cap[0] = q.dq_sync[1]; // [R11] [R12]
              d.wr_ptr = q.wr_ptr + 3'h1; // [R9]
              d.rd_state = RD_CAP;
            end
            else
              d.skip = q.skip - 3'h1; // [R7]
          end
        RD_CAP:
          if (srd_edge)
          begin
            d.cap[offset] = q.dq_sync[1]; // [R11] [R12]
            d.wr_ptr = q.wr_ptr + 3'h1; // [R9]
            if (offset == last)
            begin
              d.rx_word = d.cap;
              d.rd_ptr = q.wr_ptr + 3'h1; // [R9]
              d.burst_det = 1'b1; // [R8]
              d.rd_state = RD_IDLE;
            end
          end
        default: d.rd_state = RD_IDLE;
      endcase
    end

    // Transmit: leveling wait, then bits; strobe lags data a quarter bit.
    case (q.tx_state)
      TX_IDLE:
        if (tx_go)
        begin
          d.sh_dq = q.txw[T_DQ +: 8];
          d.sh_dqs = q.txw[T_DQS +: 8];
          d.sh_en = q.txw[T_DQEN +: 4];
          d.sh_sen = q.txw[T_DQSEN +: 4];
          d.sh_ac = q.txw[T_AC +: 4];
          d.tx_cnt = q.ctrl[C_WLD +: 8]; // [R10]
          d.ph = 3'h0;
          d.bit_idx = 3'h0;
          d.tx_state = TX_LEVEL;
        end
      TX_LEVEL:
        if (q.tx_cnt == 8'h00)
          d.tx_state = TX_SEND;
        else
          d.tx_cnt = q.tx_cnt - 8'h01; // [R10]
      TX_SEND:
      begin
        d.ph = (q.ph == PH_LAST) ? 3'h0 : q.ph + 3'h1;
        if (q.ph == 3'h0)
        begin
          d.pins.dq = q.sh_dq[0]; // [R13] [R14]
          d.sh_dq = q.sh_dq >> 1;
          if (!q.bit_idx[0])
          begin
            d.pins.dq_oe = q.sh_en[0]; // [R17] [R18]
            d.sh_en = q.sh_en >> 1;
            d.pins.addr_cmd = q.sh_ac[0]; // [R21] [R22]
            d.sh_ac = q.sh_ac >> 1;
          end
        end
        if (q.ph == PH_QTR)
        begin
          d.pins.dqs = q.sh_dqs[0]; // [R15] [R16]
          d.sh_dqs = q.sh_dqs >> 1;
          if (!q.bit_idx[0])
          begin
            d.pins.dqs_oe = q.sh_sen[0]; // [R19] [R20]
            d.sh_sen = q.sh_sen >> 1;
          end
        end
        if (q.ph == PH_LAST)
        begin
          d.bit_idx = q.bit_idx + 3'h1;
          if (q.bit_idx == last)
          begin
            d.pins.dq_oe = 1'b0;
            d.pins.dqs_oe = 1'b0;
            d.tx_state = TX_IDLE;
          end
        end
      end
      default: d.tx_state = TX_IDLE;
    endcase

    // Serializer reset wins over any traffic in the same cycle.
    if (q.ctrl[C_SRST])
    begin
      d.wr_ptr = 3'h0; // [R24]
      d.rd_ptr = 3'h0; // [R24]
      d.rd_state = RD_IDLE;
      d.tx_state = TX_IDLE;
      d.cap = 8'h00;
      d.sh_dq = 8'h00;
      d.sh_dqs = 8'h00;
      d.sh_en = 4'h0;
      d.sh_sen = 4'h0;
      d.sh_ac = 4'h0;
      d.pins = '0;
    end
  end

  // Async reset loads constants only; the strobe history starts low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.rd_state <= RD_IDLE;
      q.tx_state <= TX_IDLE;
    end
    else
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign dram_pins = q.pins;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence tx_launch;
    q.tx_state == TX_IDLE && tx_go && !q.ctrl[C_SRST];
  endsequence

  sequence tx_level_wait;
    q.tx_state == TX_LEVEL ##[1:300] q.tx_state == TX_SEND;
  endsequence

  code_gate_a: assert property ( // [R23]
    !$stable(q.dll_code) |-> !$past(q.ctrl[C_UPDN]))
    else $error("loop code moved while update was blocked");

  delay_follow_a: assert property ( // [R5]
    !q.ctrl[C_LOAD] && !q.ctrl[C_PAUSE] |=> q.delay == $past(q.dll_code))
    else $error("delay did not follow the loop code");

  load_ignore_a: assert property ( // [R4]
    q.ctrl[C_LOAD] && !step |=> $stable(q.delay))
    else $error("delay moved under load without a step");

  step_up_a: assert property ( // [R3]
    q.ctrl[C_LOAD] && !q.ctrl[C_PAUSE] && step && !pwdata[M_DIR]
    && q.delay != DLY_MAX |=> q.delay == $past(q.delay) + 6'h01)
    else $error("step up did not raise the delay by one");

  pause_hold_a: assert property ( // [R6]
    q.ctrl[C_PAUSE] && !q.ctrl[C_SRST] && !rd_go
    |=> $stable(q.wr_ptr) && $stable(q.delay))
    else $error("pointers or delay moved during pause");

  burst_src_a: assert property ( // [R8]
    $rose(q.burst_det) |-> $past(q.rd_state) == RD_CAP
    && q.rd_ptr == q.wr_ptr)
    else $error("burst detect rose outside a full capture");

  tx_seq_a: assert property ( // [R10]
    tx_launch |=> tx_level_wait)
    else $error("transmit did not level and then send");

  oe_idle_a: assert property ( // [R17]
    q.tx_state == TX_IDLE && $past(q.tx_state) == TX_SEND
    |-> !dram_pins.dq_oe && !dram_pins.dqs_oe)
    else $error("enables left on after the last bit");

  ser_reset_a: assert property ( // [R24]
    q.ctrl[C_SRST] |=> q.wr_ptr == 3'h0 && q.tx_state == TX_IDLE
    && dram_pins == '0)
    else $error("serializer reset did not clear gearing state");

  apb_answer_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("read answer was not exactly one cycle");

endmodule // ddrphy_top

// *** ddrphy_mem_model.sv ***
module ddrphy_mem_model (
  // Memory data and strobe pins
  output logic dq,
  output logic dqs
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF_NS = 80;

  // The strobe stands low between frames, as a memory in read idle does.
  initial
  begin
    dq = 1'b0;
    dqs = 1'b0;
  end

  // One read frame: pre whole preamble periods, then n data bits that change
  // with each strobe edge; the block itself must find the bit centre.
  task automatic burst(input logic [7:0] w, input int pre, input int n);
    int i;
    #3;
    for (i = 0; i < 2 * pre + n; i++)
    begin
      dqs = ~dqs;
      dq = (i < 2 * pre) ? 1'b0 : w[i - 2 * pre];
      #HALF_NS;
    end
    // The data line is flipped after the frame, so it does not keep showing the last bit.
    dq = ~dq;
  endtask
endmodule // ddrphy_mem_model

// *** ddrphy_top_tb_top.sv ***
module ddrphy_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ddrphy_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic dq_in, dqs_in, ev;
  ddrphy_pins_s dram_pins;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int lat0, lat1;

  ddrphy_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_in(dq_in),
    .dqs_in(dqs_in), .dram_pins(dram_pins));
  ddrphy_mem_model u_mem (.dq(dq_in), .dqs(dqs_in));

  // System clock, 8 ns period.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // A hang anywhere ends the run as a failure.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first so no signal is driven twice.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
      n_errors++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Status is polled with a bounded count; the caller judges the bit.
  task automatic poll(input int b);
    int n;
    for (n = 0; n < 60; n++)
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (rv[b] === 1'b1)
        break;
    end
  endtask

  task automatic rx_case(input logic g4, input logic [2:0] rs,
    input logic [7:0] w);
    logic [31:0] c;
    logic [7:0] m;
    c = 32'h2000 | (32'(g4) << C_GEAR4) | (32'(rs) << C_RSEL);
    m = g4 ? 8'hFF : 8'h0F;
    // Pause goes up alone first, so the select never moves while running.
    apb(1'b0, OFF_CTRL, 32'h0);
    wr(OFF_CTRL, rv | 32'h2);
    wr(OFF_CTRL, c | 32'h2);
    wr(OFF_CTRL, c | 32'h10000);
    u_mem.burst(w, int'(rs), g4 ? 8 : 4);
    poll(1);
    chk(32'(rv[1]), 32'h1);
    chk(32'(rv[4:2]), 32'(rv[7:5]));
    apb(1'b0, OFF_RXWORD, 32'h0);
    chk(rv & 32'(m), 32'(w & m));
  endtask

  // Samples each bit one cycle after the strobe phase has moved.
  task automatic tx_case(input logic g4, input logic [7:0] wl,
    input logic [31:0] tw, output int lat);
    int i;
    logic [31:0] c;
    ddrphy_pins_s p;
    c = 32'h2000 | (32'(g4) << C_GEAR4) | (32'(wl) << C_WLD);
    wr(OFF_TXWORD, tw);
    // Pause goes up alone first, so leveling never moves while running.
    apb(1'b0, OFF_CTRL, 32'h0);
    wr(OFF_CTRL, rv | 32'h2);
    wr(OFF_CTRL, c | 32'h2);
    wr(OFF_CTRL, c | 32'h20000);
    lat = 0;
    while (dram_pins.dq_oe !== 1'b1 && lat < 300)
    begin
      @(posedge pclk);
      lat++;
    end
    // A transmit that never starts is a failure, not a silent skip.
    if (lat == 300)
      n_errors++;
    for (i = 0; i < (g4 ? 8 : 4); i++)
    begin
      repeat ((i == 0) ? 1 : 4) @(posedge pclk);
      p = dram_pins;
      chk(32'({p.dq, p.dqs}), 32'({tw[i], tw[8 + i]}));
      chk(32'(p.dq_oe), 32'(tw[16 + i / 2]));
      chk(32'(p.dqs_oe), 32'(tw[20 + i / 2]));
      chk(32'(p.addr_cmd), 32'(tw[24 + i / 2]));
    end
    repeat (4) @(posedge pclk);
    chk(32'({dram_pins.dq_oe, dram_pins.dqs_oe}), 32'h0);
  endtask

  // Main sequence: reset, lock, margin, capture, serializer reset, transmit.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rv, 32'h2000);
    chk(32'(dram_pins), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, ev}, 32'h1);
    chk(rv, 32'h0);
    wr(OFF_CTRL, 32'h2002);
    wr(OFF_CTRL, 32'h0002);
    u_mem.burst(8'h00, 0, 8);
    poll(0);
    chk(32'(rv[0]), 32'h1);
    wr(OFF_CTRL, 32'h2002);
    wr(OFF_CTRL, 32'h2000);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk(rv, 32'h145);
    u_mem.burst(8'h00, 0, 8);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk(rv, 32'h145);
    wr(OFF_CTRL, 32'h2001);
    wr(OFF_MARGIN, 32'h1);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk(rv, 32'h185);
    wr(OFF_MARGIN, 32'h3);
    wr(OFF_MARGIN, 32'h3);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk(rv, 32'h105);
    wr(OFF_CTRL, 32'h2000);
    apb(1'b0, OFF_DELAY, 32'h0);
    chk(rv, 32'h145);
    rx_case(1'b0, 3'h0, 8'h0A);
    rx_case(1'b1, 3'h2, 8'hC5);
    rx_case(1'b0, 3'h1, 8'h06);
    // The read select of the last capture is kept, since pause is low here.
    wr(OFF_CTRL, 32'hA004);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rv & 32'h1FC, 32'h0);
    wr(OFF_CTRL, 32'h2004);
    tx_case(1'b0, 8'h00, 32'h02210C09, lat0);
    tx_case(1'b1, 8'h05, 32'h06AD3CB2, lat1);
    chk(32'(lat1), 32'(lat0 + 5));
    conclude();
  end
endmodule // ddrphy_top_tb_top
